//--- elsfc_top.sv
// Ethernet/LLC/SNAP comparator stage with AHB-Lite registers
`timescale 1ns/1ps
module elsfc_top
    import elsfc_pkg::*;
#(
    parameter bit FIRST_STAGE = 1'b1
) (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic hsel_in,
    input wire logic [11:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic start_in,
    input wire logic [elsfc_pkg::HDR_W-1:0] hdr_in,
    input wire logic chan_in,
    input wire logic [7:0] start_pos_in,
    output logic done_out,
    output logic match_out,
    output logic [elsfc_pkg::FLOW_W-1:0] flow_out,
    output logic [2:0] next_stage_out,
    output logic [7:0] next_pos_out,
    output logic [4:0] sig_offset_out
);
    import elsfc_pkg::*;

    logic [31:0] np_ctrl_r;
    logic [15:0] tpid_r;
    logic [15:0] etype_r;
    logic [7:0] offset_r;
    logic [31:0] fl_ctrl_r [NUM_FLOWS];
    logic [47:0] fl_addr_r [NUM_FLOWS];
    logic [23:0] fl_tag1_r [NUM_FLOWS];
    logic [23:0] fl_tag2_r [NUM_FLOWS];
    logic [23:0] fl_range_r [NUM_FLOWS];
    logic [31:0] match_cnt_r;
    logic [31:0] miss_cnt_r;

    logic wr_pend_r;
    logic [11:0] wr_addr_r;
    logic [31:0] rdata_nxt;

    elsfc_state_t state_r;
    logic [HDR_W-1:0] hdr_r;
    logic chan_r;
    logic [7:0] pos_r;

    logic [2:0] next_stage;
    logic [4:0] sig_off;
    logic pbb;
    logic et_chk;

    // np_ctrl: 2:0 next stage, 7:3 signature offset, 8 bridging, 9 ethertype check
    assign next_stage = np_ctrl_r[2:0];
    assign sig_off = np_ctrl_r[7:3];
    // Second stage hard-wires bridging off
    assign pbb = FIRST_STAGE ? np_ctrl_r[8] : 1'b0;
    assign et_chk = np_ctrl_r[9];

    function automatic logic flow_sel(input logic [11:0] a, input int f, input logic [4:0] r);
        flow_sel = a == REG_FLOW_BASE + 12'(f) * REG_FLOW_STRIDE + {7'h00, r};
    endfunction

    // AHB-Lite slave: zero wait states, writes land in the data phase
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
        end else if (hready_in) begin
            wr_pend_r <= hsel_in && htrans_in[1] && hwrite_in;
            wr_addr_r <= haddr_in;
        end
    end

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (haddr_in)
            REG_NP_CTRL: rdata_nxt = {22'h000000, np_ctrl_r[9:0]};
            REG_NP_TPID: rdata_nxt = {16'h0000, tpid_r};
            REG_NP_ETYPE: rdata_nxt = {16'h0000, etype_r};
            REG_NP_OFFSET: rdata_nxt = {24'h000000, offset_r};
            REG_STATUS: rdata_nxt = {match_cnt_r[15:0], miss_cnt_r[15:0]};
            default: rdata_nxt = 32'h0000_0000;
        endcase
        for (int f = 0; f < NUM_FLOWS; f++) begin
            if (flow_sel(haddr_in, f, FL_CTRL)) rdata_nxt = {16'h0000, fl_ctrl_r[f][15:0]};
            if (flow_sel(haddr_in, f, FL_ADDR_LO)) rdata_nxt = fl_addr_r[f][31:0];
            if (flow_sel(haddr_in, f, FL_ADDR_HI)) rdata_nxt = {16'h0000, fl_addr_r[f][47:32]};
            if (flow_sel(haddr_in, f, FL_TAG1)) rdata_nxt = {8'h00, fl_tag1_r[f]};
            if (flow_sel(haddr_in, f, FL_TAG2)) rdata_nxt = {8'h00, fl_tag2_r[f]};
            if (flow_sel(haddr_in, f, FL_RANGE)) rdata_nxt = {8'h00, fl_range_r[f]};
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            hrdata_out <= 32'h0000_0000;
        end else if (hready_in && hsel_in && htrans_in[1] && !hwrite_in) begin
            hrdata_out <= rdata_nxt;
        end
    end

    // Shared next-protocol set, one for all flows
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            np_ctrl_r <= NP_CTRL_RST;
            tpid_r <= TPID_RST;
            etype_r <= 16'h0000;
            offset_r <= OFFSET_RST;
        end else if (wr_pend_r) begin
            case (wr_addr_r)
                REG_NP_CTRL: np_ctrl_r <= {22'h000000, hwdata_in[9:0]};
                REG_NP_TPID: tpid_r <= hwdata_in[15:0];
                REG_NP_ETYPE: etype_r <= hwdata_in[15:0];
                REG_NP_OFFSET: offset_r <= hwdata_in[7:0];
                default: offset_r <= offset_r;
            endcase
        end
    end

    generate
        for (genvar g = 0; g < NUM_FLOWS; g++) begin : g_flow_regs
            always_ff @(posedge core_clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    fl_ctrl_r[g] <= 32'h0000_0000;
                    fl_addr_r[g] <= 48'h0000_0000_0000;
                    fl_tag1_r[g] <= 24'h000000;
                    fl_tag2_r[g] <= 24'h000000;
                    fl_range_r[g] <= 24'h000000;
                end else if (wr_pend_r) begin
                    if (flow_sel(wr_addr_r, g, FL_CTRL)) begin
                        fl_ctrl_r[g] <= {16'h0000, hwdata_in[15:0]};
                    end
                    if (flow_sel(wr_addr_r, g, FL_ADDR_LO)) begin
                        fl_addr_r[g][31:0] <= hwdata_in;
                    end
                    if (flow_sel(wr_addr_r, g, FL_ADDR_HI)) begin
                        fl_addr_r[g][47:32] <= hwdata_in[15:0];
                    end
                    if (flow_sel(wr_addr_r, g, FL_TAG1)) begin
                        fl_tag1_r[g] <= hwdata_in[23:0];
                    end
                    if (flow_sel(wr_addr_r, g, FL_TAG2)) begin
                        fl_tag2_r[g] <= hwdata_in[23:0];
                    end
                    if (flow_sel(wr_addr_r, g, FL_RANGE)) begin
                        fl_range_r[g] <= hwdata_in[23:0];
                    end
                end
            end
        end
    endgenerate

    // Frame capture and evaluation sequencing
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_r <= ELSFC_ST_IDLE;
            hdr_r <= '0;
            chan_r <= 1'b0;
            pos_r <= 8'h00;
        end else begin
            case (state_r)
                ELSFC_ST_IDLE: begin
                    if (start_in) begin
                        hdr_r <= hdr_in;
                        chan_r <= chan_in;
                        pos_r <= start_pos_in;
                        state_r <= ELSFC_ST_EVAL;
                    end
                end
                ELSFC_ST_EVAL: state_r <= ELSFC_ST_DONE;
                ELSFC_ST_DONE: state_r <= ELSFC_ST_IDLE;
                default: state_r <= ELSFC_ST_IDLE;
            endcase
        end
    end

    logic [47:0] da;
    logic [47:0] sa;
    logic [1:0] ntags;
    logic tag1_s;
    logic tag1_c;
    logic tag2_s;
    logic tag2_c;
    logic tag2_i;
    logic [11:0] vid1;
    logic [11:0] vid2;
    logic [23:0] isid;
    logic is_len;
    logic llc_ok;
    logic [15:0] etype;

    elsfc_hdr_parse u_parse (
        .hdr_in(hdr_r),
        .tpid_in(tpid_r),
        .pbb_in(pbb),
        .da_out(da),
        .sa_out(sa),
        .ntags_out(ntags),
        .tag1_s_out(tag1_s),
        .tag1_c_out(tag1_c),
        .tag2_s_out(tag2_s),
        .tag2_c_out(tag2_c),
        .tag2_i_out(tag2_i),
        .vid1_out(vid1),
        .vid2_out(vid2),
        .isid_out(isid),
        .is_len_out(is_len),
        .llc_ok_out(llc_ok),
        .etype_out(etype)
    );

    logic [NUM_FLOWS-1:0] hits;

    // Each flow is an independent match set
    generate
        for (genvar g = 0; g < NUM_FLOWS; g++) begin : g_flows
            elsfc_flow_match u_flow (
                .ctrl_in(fl_ctrl_r[g]),
                .addr_in(fl_addr_r[g]),
                .tag1_in(fl_tag1_r[g]),
                .tag2_in(fl_tag2_r[g]),
                .range_in(fl_range_r[g]),
                .chan_in(fl_ctrl_r[g][1 + int'(chan_r)]),
                .pbb_in(pbb),
                .da_in(da),
                .sa_in(sa),
                .ntags_in(ntags),
                .tag1_s_in(tag1_s),
                .tag1_c_in(tag1_c),
                .tag2_s_in(tag2_s),
                .tag2_c_in(tag2_c),
                .tag2_i_in(tag2_i),
                .vid1_in(vid1),
                .vid2_in(vid2),
                .isid_in(isid),
                .is_len_in(is_len),
                .llc_ok_in(llc_ok),
                .hit_out(hits[g])
            );
        end
    endgenerate

    logic np_ok;
    logic any_hit;
    logic [FLOW_W-1:0] first_hit;

    always_comb begin
        // Final ethertype against the shared expected value
        np_ok = !(et_chk && !is_len) || etype == etype_r;
        if (et_chk && is_len) begin
            np_ok = etype == etype_r;
        end
        any_hit = 1'b0;
        first_hit = '0;
        // Lowest numbered passing flow wins
        for (int f = NUM_FLOWS - 1; f >= 0; f--) begin
            if (hits[f]) begin
                any_hit = 1'b1;
                first_hit = FLOW_W'(f);
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            done_out <= 1'b0;
            match_out <= 1'b0;
            flow_out <= '0;
            next_stage_out <= 3'h0;
            next_pos_out <= 8'h00;
            sig_offset_out <= 5'h00;
            match_cnt_r <= 32'h0000_0000;
            miss_cnt_r <= 32'h0000_0000;
        end else begin
            done_out <= state_r == ELSFC_ST_EVAL;
            if (state_r == ELSFC_ST_EVAL) begin
                // No flow passing means no match
                match_out <= any_hit && np_ok;
                // Single result bundle to the engine controller
                flow_out <= first_hit;
                next_stage_out <= next_stage;
                next_pos_out <= pos_r + offset_r;
                sig_offset_out <= sig_off;
                if (any_hit && np_ok) begin
                    match_cnt_r <= match_cnt_r + 32'h0000_0001;
                end else begin
                    miss_cnt_r <= miss_cnt_r + 32'h0000_0001;
                end
            end
        end
    end
endmodule

//--- elsfc_pkg.sv
// Shared constants and types for the Ethernet/LLC/SNAP flow comparator
package elsfc_pkg;
    localparam int NUM_FLOWS = 8;
    localparam int NUM_CHAN = 2;
    localparam int FLOW_W = 3;
    localparam int HDR_BYTES = 36;
    localparam int HDR_W = HDR_BYTES * 8;

    localparam logic [15:0] CTAG_TPID = 16'h8100;
    localparam logic [15:0] LEN_LIMIT = 16'h0600;
    localparam logic [7:0] LLC_SAP_A = 8'hAA;
    localparam logic [7:0] LLC_SAP_B = 8'hAB;
    localparam logic [7:0] LLC_CTL_UI = 8'h03;
    localparam logic [15:0] ITAG_TPID_DEF = 16'h88E7;
    localparam logic [7:0] SNAP_LEN = 8'h08;

    // Register byte offsets
    localparam logic [11:0] REG_NP_CTRL = 12'h000;
    localparam logic [11:0] REG_NP_TPID = 12'h004;
    localparam logic [11:0] REG_NP_ETYPE = 12'h008;
    localparam logic [11:0] REG_NP_OFFSET = 12'h00C;
    localparam logic [11:0] REG_STATUS = 12'h010;
    localparam logic [11:0] REG_FLOW_BASE = 12'h100;
    localparam logic [11:0] REG_FLOW_STRIDE = 12'h020;
    localparam logic [4:0] FL_CTRL = 5'h00;
    localparam logic [4:0] FL_ADDR_LO = 5'h04;
    localparam logic [4:0] FL_ADDR_HI = 5'h08;
    localparam logic [4:0] FL_TAG1 = 5'h0C;
    localparam logic [4:0] FL_TAG2 = 5'h10;
    localparam logic [4:0] FL_RANGE = 5'h14;

    localparam logic [31:0] NP_CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] TPID_RST = 16'h88A8;
    localparam logic [7:0] OFFSET_RST = 8'h0E;

    typedef enum logic [1:0] {
        ELSFC_ST_IDLE = 2'b00,
        ELSFC_ST_EVAL = 2'b01,
        ELSFC_ST_DONE = 2'b10
    } elsfc_state_t;
endpackage

//--- elsfc_hdr_parse.sv
// Header parser: locates tags, LLC/SNAP and final ethertype
`timescale 1ns/1ps
module elsfc_hdr_parse
    import elsfc_pkg::*;
(
    input wire logic [elsfc_pkg::HDR_W-1:0] hdr_in,
    input wire logic [15:0] tpid_in,
    input wire logic pbb_in,
    output logic [47:0] da_out,
    output logic [47:0] sa_out,
    output logic [1:0] ntags_out,
    output logic tag1_s_out,
    output logic tag1_c_out,
    output logic tag2_s_out,
    output logic tag2_c_out,
    output logic tag2_i_out,
    output logic [11:0] vid1_out,
    output logic [11:0] vid2_out,
    output logic [23:0] isid_out,
    output logic is_len_out,
    output logic llc_ok_out,
    output logic [15:0] etype_out
);
    function automatic logic [7:0] byte_at(input logic [HDR_W-1:0] h, input int idx);
        byte_at = h[HDR_W-1-8*idx -: 8];
    endfunction

    function automatic logic [15:0] word_at(input logic [HDR_W-1:0] h, input int idx);
        word_at = {byte_at(h, idx), byte_at(h, idx + 1)};
    endfunction

    logic [15:0] t1;
    logic [15:0] t2;
    logic [15:0] lt;
    logic [15:0] snap_et;
    logic [15:0] snap_vid;
    logic [15:0] snap_et2;
    logic t1_tag;
    logic t2_tag;
    int p;

    always_comb begin
        p = 12;
        da_out = {byte_at(hdr_in, 0), byte_at(hdr_in, 1), byte_at(hdr_in, 2),
                  byte_at(hdr_in, 3), byte_at(hdr_in, 4), byte_at(hdr_in, 5)};
        sa_out = {byte_at(hdr_in, 6), byte_at(hdr_in, 7), byte_at(hdr_in, 8),
                  byte_at(hdr_in, 9), byte_at(hdr_in, 10), byte_at(hdr_in, 11)};
        t1 = word_at(hdr_in, 12);
        t1_tag = (t1 == CTAG_TPID) || (t1 == tpid_in);
        t2 = word_at(hdr_in, 16);
        // Bridging: second tag is a six-byte I-tag
        t2_tag = t1_tag && ((t2 == CTAG_TPID) || (t2 == tpid_in) || (pbb_in && t2 == ITAG_TPID_DEF));
        tag1_c_out = t1 == CTAG_TPID;
        tag1_s_out = t1 == tpid_in;
        tag2_c_out = t2 == CTAG_TPID;
        tag2_s_out = t2 == tpid_in;
        tag2_i_out = t2 == ITAG_TPID_DEF;
        vid1_out = t1_tag ? 12'(word_at(hdr_in, 14)) : 12'h000;
        vid2_out = t2_tag ? 12'(word_at(hdr_in, 18)) : 12'h000;
        isid_out = {byte_at(hdr_in, 19), byte_at(hdr_in, 20), byte_at(hdr_in, 21)};
        ntags_out = t2_tag ? 2'd2 : (t1_tag ? 2'd1 : 2'd0);
        // Up to two tags, then LLC and SNAP
        p = 12 + 4 * int'(ntags_out);
        if (pbb_in && t2_tag && tag2_i_out) begin
            p = 22;
        end
        lt = word_at(hdr_in, p);
        is_len_out = lt < LEN_LIMIT;
        // LLC SAP values and control byte
        llc_ok_out = (byte_at(hdr_in, p + 2) == LLC_SAP_A || byte_at(hdr_in, p + 2) == LLC_SAP_B)
                  && (byte_at(hdr_in, p + 3) == LLC_SAP_A || byte_at(hdr_in, p + 3) == LLC_SAP_B)
                  && byte_at(hdr_in, p + 4) == LLC_CTL_UI;
        snap_et = word_at(hdr_in, p + 8);
        snap_vid = word_at(hdr_in, p + 10);
        snap_et2 = word_at(hdr_in, p + 12);
        etype_out = lt;
        if (is_len_out) begin
            // Tag right after SNAP when SNAP type is a VLAN TPID
            if ((snap_et == CTAG_TPID) || (snap_et == tpid_in)) begin
                etype_out = snap_et2;
                if (ntags_out == 2'd0) begin
                    vid1_out = snap_vid[11:0];
                end
            end else begin
                etype_out = snap_et;
            end
        end
    end
endmodule

//--- elsfc_flow_match.sv
// One flow's address and tag match set
`timescale 1ns/1ps
module elsfc_flow_match
    import elsfc_pkg::*;
(
    input wire logic [31:0] ctrl_in,
    input wire logic [47:0] addr_in,
    input wire logic [23:0] tag1_in,
    input wire logic [23:0] tag2_in,
    input wire logic [23:0] range_in,
    input wire logic chan_in,
    input wire logic pbb_in,
    input wire logic [47:0] da_in,
    input wire logic [47:0] sa_in,
    input wire logic [1:0] ntags_in,
    input wire logic tag1_s_in,
    input wire logic tag1_c_in,
    input wire logic tag2_s_in,
    input wire logic tag2_c_in,
    input wire logic tag2_i_in,
    input wire logic [11:0] vid1_in,
    input wire logic [11:0] vid2_in,
    input wire logic [23:0] isid_in,
    input wire logic is_len_in,
    input wire logic llc_ok_in,
    output logic hit_out
);
    // ctrl: 0 enable, 2:1 channel mask, 4:3 tags, 5 tag1 kind, 6 tag2 kind,
    // 7 length mode, 8 verify, 10:9 range, 12:11 addr select, 15:13 addr kinds
    function automatic logic addr_ok(input logic [47:0] a, input logic [47:0] m,
                                     input logic [2:0] k);
        // Group bit is the first transmitted bit of the first byte
        addr_ok = (k[0] && a == m) || (k[1] && !a[40]) || (k[2] && a[40]);
    endfunction

    function automatic logic mm_ok(input logic [11:0] v, input logic [23:0] mm);
        mm_ok = ((v ^ mm[23:12]) & mm[11:0]) == 12'h000;
    endfunction

    logic a_ok;
    logic t_ok;
    logic f_ok;
    logic [2:0] kinds;

    always_comb begin
        kinds = ctrl_in[15:13];
        // Address selector, value 3 never matches
        case (ctrl_in[12:11])
            2'd0: a_ok = addr_ok(da_in, addr_in, kinds);
            2'd1: a_ok = addr_ok(sa_in, addr_in, kinds);
            2'd2: a_ok = addr_ok(da_in, addr_in, kinds) || addr_ok(sa_in, addr_in, kinds);
            default: a_ok = 1'b0;
        endcase
        t_ok = 1'b1;
        if (pbb_in) begin
            // Bridging: two tags, second an I-tag, I-tag always checked
            t_ok = ntags_in == 2'd2 && tag2_i_in && tag1_s_in
                && isid_in == {range_in[23:12], range_in[11:0]};
            if (ctrl_in[8]) begin
                t_ok = t_ok && mm_ok(vid1_in, tag1_in);
            end
        end else if (ctrl_in[8]) begin
            // Count, kind and value of tags
            t_ok = ntags_in == ctrl_in[4:3];
            if (ntags_in != 2'd0) begin
                t_ok = t_ok && (ctrl_in[5] ? tag1_s_in : tag1_c_in) && mm_ok(vid1_in, tag1_in);
            end
            if (ntags_in == 2'd2) begin
                t_ok = t_ok && (ctrl_in[6] ? tag2_s_in : tag2_c_in) && mm_ok(vid2_in, tag2_in);
            end
            // Inclusive bounds
            case (ctrl_in[10:9])
                2'd1: t_ok = t_ok && vid1_in >= range_in[11:0] && vid1_in <= range_in[23:12];
                2'd2: t_ok = t_ok && vid2_in >= range_in[11:0] && vid2_in <= range_in[23:12];
                default: t_ok = t_ok;
            endcase
        end
        // Length mode set: type I needs LLC/SNAP, type II always passes; clear: only type II passes
        f_ok = ctrl_in[7] ? (!is_len_in || llc_ok_in) : !is_len_in;
        // Flow enable and channel mask
        hit_out = ctrl_in[0] && chan_in && a_ok && t_ok && f_ok;
    end
endmodule

//--- elsfc_sva.sv
// Port checker for the comparator stage
`timescale 1ns/1ps
module elsfc_sva
    import elsfc_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic hsel_in,
    input wire logic [11:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic start_in,
    input wire logic [7:0] start_pos_in,
    input wire logic done_out,
    input wire logic match_out,
    input wire logic [elsfc_pkg::FLOW_W-1:0] flow_out,
    input wire logic [2:0] next_stage_out,
    input wire logic [7:0] next_pos_out,
    input wire logic [4:0] sig_offset_out
);
    logic wv_r;
    logic [11:0] wa_r;
    logic [7:0] off_r;
    logic [7:0] ctl_r;
    logic [7:0] pos_r;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    // Shadow of offset and control registers
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wv_r <= 1'b0;
            off_r <= OFFSET_RST;
            ctl_r <= NP_CTRL_RST[7:0];
        end else begin
            if (hready_in) wv_r <= hsel_in & htrans_in[1] & hwrite_in;
            if (wv_r && hready_in && wa_r == REG_NP_OFFSET) off_r <= hwdata_in[7:0];
            if (wv_r && hready_in && wa_r == REG_NP_CTRL) ctl_r <= hwdata_in[7:0];
        end
    end
    always_ff @(posedge core_clk_in) begin
        if (hready_in) wa_r <= haddr_in;
        if (start_in) pos_r <= start_pos_in;
    end
    sequence s_take;
        start_in && !$past(start_in) && !$past(start_in, 2);
    endsequence
    sequence s_answer;
        ##[2:3] done_out;
    endsequence
    bus_okay_a: assert property (hreadyout_out && !hresp_out)
        else $error("bus not okay");
    answer_lat_a: assert property (s_take |-> s_answer)
        else $error("no result");
    done_pulse_a: assert property (done_out |=> !done_out)
        else $error("done too long");
    lone_done_a: assert property (done_out |-> $past(start_in, 2) || $past(start_in, 3))
        else $error("stray done");
    result_hold_a: assert property (!done_out |-> $stable({match_out, flow_out,
        next_stage_out, next_pos_out, sig_offset_out}))
        else $error("result moved");
    next_pos_a: assert property (done_out |-> next_pos_out == pos_r + off_r)
        else $error("next pos wrong");
    next_stage_a: assert property (done_out |-> next_stage_out == ctl_r[2:0])
        else $error("next stage wrong");
    sig_off_a: assert property (done_out |-> sig_offset_out == ctl_r[7:3])
        else $error("sig offset wrong");
endmodule
bind elsfc_top elsfc_sva i_elsfc_sva (.*);

//--- elsfc_ctl_model.sv
// Engine controller model that launches frames into the stage
`timescale 1ns/1ps
module elsfc_ctl_model
    import elsfc_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic go_in,
    input wire logic [elsfc_pkg::HDR_W-1:0] frame_in,
    input wire logic chan_sel_in,
    input wire logic [7:0] pos_in,
    output logic start_out,
    output logic [elsfc_pkg::HDR_W-1:0] hdr_out,
    output logic chan_out,
    output logic [7:0] pos_out
);
    // Scramble header after the take cycle
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            start_out <= 1'b0;
            hdr_out <= '0;
            chan_out <= 1'b0;
            pos_out <= 8'h00;
        end else begin
            start_out <= go_in;
            hdr_out <= go_in ? frame_in : ~hdr_out;
            chan_out <= go_in ? chan_sel_in : ~chan_out;
            pos_out <= pos_in;
        end
    end
endmodule

//--- testbench.sv
// Self-checking bench for the comparator stage
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin fails++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
module testbench;
    import elsfc_pkg::*;
    logic core_clk_in, resetn_in, hsel_in, hwrite_in, hready_in, start_in, chan_in;
    logic hreadyout_out, hresp_out, done_out, match_out, rd_q, go, gchan;
    logic [11:0] haddr_in;
    logic [1:0] htrans_in;
    logic [2:0] hsize_in, next_stage_out;
    logic [31:0] hwdata_in, hrdata_out, e, rng;
    logic [HDR_W-1:0] hdr_in, gfrm;
    logic [7:0] start_pos_in, gpos, next_pos_out;
    logic [FLOW_W-1:0] flow_out;
    logic [4:0] sig_offset_out;
    logic [31:0] expq[$];
    logic [11:0] wa[7];
    logic [31:0] wd[7];
    int fails = 0, tests_run = 0, cyc = 0;
    localparam logic [47:0] DA = 48'h0211_2233_4455;
    localparam logic [47:0] SA = 48'h0A00_0000_0001;
    localparam logic [15:0] ET = 16'h88F7;
    localparam logic [11:0] VID = 12'h123;
    assign hready_in = hreadyout_out;
    elsfc_top i_elsfc_top (.core_clk_in, .resetn_in, .hsel_in, .haddr_in, .htrans_in,
        .hwrite_in, .hsize_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out,
        .start_in, .hdr_in, .chan_in, .start_pos_in, .done_out, .match_out, .flow_out,
        .next_stage_out, .next_pos_out, .sig_offset_out);
    elsfc_ctl_model i_elsfc_ctl_model (.core_clk_in, .resetn_in, .go_in(go), .frame_in(gfrm),
        .chan_sel_in(gchan), .pos_in(gpos), .start_out(start_in), .hdr_out(hdr_in),
        .chan_out(chan_in), .pos_out(start_pos_in));
    initial begin
        core_clk_in = 1'b0;
        forever #4 core_clk_in = ~core_clk_in;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    function automatic logic [HDR_W-1:0] mk(input logic [47:0] da, input logic [11:0] v,
        input logic [15:0] et, input logic [47:0] sa);
        return {da, sa, CTAG_TPID, 4'h0, v, et, 144'h0};
    endfunction
    // Result word: stage 5, start plus 0x12, signature 0x0C
    function automatic logic [31:0] ex(input logic [2:0] fl, input logic [7:0] p);
        return {12'h000, 1'b1, fl, 3'h5, 8'(p + 8'h12), 5'h0C};
    endfunction
    function automatic logic [11:0] fa(input int f, input logic [4:0] o);
        return REG_FLOW_BASE + 12'(f) * REG_FLOW_STRIDE + {7'h00, o};
    endfunction
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        hsel_in <= 1'b1;
        htrans_in <= 2'h2;
        hwrite_in <= w;
        haddr_in <= a;
        do @(posedge core_clk_in); while (hready_in !== 1'b1);
        htrans_in <= 2'h0;
        hwdata_in <= d;
        if (!w) expq.push_back(d);
        rd_q <= !w;
        do @(posedge core_clk_in); while (hready_in !== 1'b1);
        rd_q <= 1'b0;
    endtask
    // Go held for n cycles: a second start is ignored
    task automatic frame(input logic [HDR_W-1:0] f, input logic c, input logic [7:0] p,
        input logic [31:0] x, input int n);
        expq.push_back(x);
        @(posedge core_clk_in);
        go <= 1'b1;
        gfrm <= f;
        gchan <= c;
        gpos <= p;
        repeat (n) @(posedge core_clk_in);
        go <= 1'b0;
        repeat (6) @(posedge core_clk_in);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            end_of_test();
        end
    end
    always @(posedge core_clk_in) begin
        if ((rd_q === 1'b1 && hready_in === 1'b1) || done_out === 1'b1) begin
            if (expq.size() == 0) begin
                fails++;
                $display("BAD result exp none got %h", match_out);
            end else begin
                e = expq.pop_front();
                if (rd_q === 1'b1) `CHK("hrdata", e, hrdata_out)
                else if (e[31]) `CHK("miss", 1'b0, match_out)
                else `CHK("result", e[19:0], {match_out, flow_out, next_stage_out,
                    next_pos_out, sig_offset_out})
            end
        end
    end
    initial begin
        {hsel_in, hwrite_in, go, gchan, rd_q} = '0;
        {haddr_in, htrans_in, hwdata_in, gfrm, gpos} = '0;
        hsize_in = 3'h2;
        rng = 32'd93;
        resetn_in = 1'b0;
        repeat (2) @(posedge core_clk_in);
        resetn_in <= 1'b1;
        ahb(0, REG_NP_CTRL, NP_CTRL_RST);
        ahb(0, REG_NP_TPID, {16'h0000, TPID_RST});
        ahb(0, REG_NP_OFFSET, {24'h0, OFFSET_RST});
        ahb(0, fa(0, FL_CTRL), 32'h0);
        ahb(0, 12'h7FC, 32'h0);
        $display("test reset values done");
        wa = '{REG_NP_CTRL, REG_NP_ETYPE, REG_NP_OFFSET, fa(2, FL_CTRL), fa(2, FL_ADDR_LO),
            fa(2, FL_ADDR_HI), fa(2, FL_TAG1)};
        wd = '{32'h0000_0265, {16'h0, ET}, 32'h12, 32'h210B, DA[31:0], {16'h0, DA[47:32]},
            {8'h00, VID, 12'hFFF}};
        foreach (wa[i]) begin
            ahb(1, wa[i], wd[i]);
            ahb(0, wa[i], wd[i]);
        end
        ahb(1, fa(5, FL_CTRL), 32'h500F);
        $display("test registers done");
        frame(mk(DA, VID, ET, SA), 0, 8'h0E, ex(2, 8'h0E), 1);
        frame(mk(DA, VID, ET, SA), 1, 8'h20, ex(5, 8'h20), 1);
        frame(mk(DA, VID ^ 12'h001, ET, SA), 0, 8'hF0, ex(5, 8'hF0), 1);
        frame(mk(DA, VID, ET ^ 16'h0001, SA), 0, 8'h0E, 32'h8000_0000, 1);
        frame(mk(DA, VID, ET, SA), 0, 8'h01, ex(2, 8'h01), 2);
        $display("test frames done");
        repeat (8) begin
            rng = xs(rng);
            frame(mk({rng[15:8], 8'h01, rng}, rng[11:0], ET, {rng[7:0], 8'h01, ~rng}),
                rng[3], rng[31:24], (rng[8] & rng[0]) ? 32'h8000_0000 : ex(5, rng[31:24]),
                1);
        end
        ahb(1, fa(5, FL_CTRL), 32'h0);
        frame(mk(DA, VID, ET, SA), 1, 8'h20, 32'h8000_0000, 1);
        $display("test random and disable done");
        if (expq.size() != 0) fails++;
        end_of_test();
    end
endmodule
